// ### pkg/scpm_pkg.sv
`default_nettype none
package scpm_pkg;

   // ==========================================================================
   // Register map (byte addresses)
   // ==========================================================================
   localparam logic [7:0] SYS_CLK_CTRL_OFF = 8'h00;
   localparam logic [7:0] PLL_CTRL_OFF     = 8'h04;
   localparam logic [7:0] OSC_CTRL_OFF     = 8'h08;
   localparam logic [7:0] STATUS_OFF       = 8'h0c;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int SEL_LSB     = 5;
   localparam int HS_SRC_BIT  = 3;
   localparam int LS_SRC_BIT  = 2;
   localparam int HS_IDLE_BIT = 1;
   localparam int LS_IDLE_BIT = 0;
   localparam int PLL_EN_BIT  = 0;
   localparam int PLL_OS_LSB  = 2;
   localparam int HXT_EN_BIT  = 0;
   localparam int HS_RC_OSC_EN_BIT = 1;
   localparam int LXT_EN_BIT  = 2;
   localparam int WDT_EN_BIT  = 3;

   // ==========================================================================
   // Reset values and constants
   // ==========================================================================
   localparam logic [7:0] SYS_CLK_CTRL_RST = 8'h40;
   localparam logic [7:0] PLL_CTRL_RST     = 8'h00;
   localparam logic [7:0] OSC_CTRL_RST     = 8'h02;
   localparam logic [2:0] SEL_SUB          = 3'h7;
   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;

   typedef enum {MODE_NORMAL, MODE_SLOW, MODE_SLEEP, MODE_IDLE_LS,
                 MODE_IDLE_BOTH, MODE_IDLE_HS} scpm_mode_t;

   // Clock gate enables handed to the clock tree
   typedef struct packed {
      logic cpu;
      logic hs_osc;
      logic ls_osc;
      logic sub_periph;
      logic wdt;
      logic pll;
      logic usb_active;
   } scpm_gates_t;

endpackage

`default_nettype wire

// ### logic/scpm_top.sv
// Functional notes
// - Select field codes 0-6 high speed, 7 sub clock
// - High speed divided by 1 to 64
// - High speed from crystal, RC or PLL
// - Sub clock from low crystal or RC
// - Slow mode keeps hs oscillator per enable
// - Halt, both idle clear: sleep
// - Watchdog clock follows watchdog enable when halted
// - Halt, ls idle only: keep low oscillator
// - Halt, both idle set: keep both
// - Slow mode PLL clock follows PLL enable
// - USB inactive in low-speed idle or sleep
// - PLL provides 6, 12 or 16 MHz
// - Run modes keep CPU and sub clock
// - Halt, hs idle only: keep hs oscillator
// - Select field bits 7-5, reset code 010
// - Source select bits: 0 RC, 1 crystal
// - Idle enables at bits 1 and 0
`timescale 1ns/10ps
`default_nettype none

module scpm_top
(
   input  wire logic                REF_CLK,
   input  wire logic                RST_N,
   input  wire logic                HXT_CLK,
   input  wire logic                HS_RC_OSC_CLK,
   input  wire logic                PLL_CLK,
   input  wire logic                LXT_CLK,
   input  wire logic                LS_RC_OSC_CLK,
   input  wire logic                HALT,
   input  wire logic                WAKE,
   output logic                     SYS_CLK_EN,
   output scpm_pkg::scpm_gates_t    GATES,
   output logic [2:0]               PLL_FREQ_SEL,
   output logic [2:0]               MODE,
   input  wire logic [7:0]          S_AXI_AWADDR,
   input  wire logic                S_AXI_AWVALID,
   output logic                     S_AXI_AWREADY,
   input  wire logic [31:0]         S_AXI_WDATA,
   input  wire logic [3:0]          S_AXI_WSTRB,
   input  wire logic                S_AXI_WVALID,
   output logic                     S_AXI_WREADY,
   output logic [1:0]               S_AXI_BRESP,
   output logic                     S_AXI_BVALID,
   input  wire logic                S_AXI_BREADY,
   input  wire logic [7:0]          S_AXI_ARADDR,
   input  wire logic                S_AXI_ARVALID,
   output logic                     S_AXI_ARREADY,
   output logic [31:0]              S_AXI_RDATA,
   output logic [1:0]               S_AXI_RRESP,
   output logic                     S_AXI_RVALID,
   input  wire logic                S_AXI_RREADY
);

   logic [7:0]           sys_clk_ctrl_reg_ff;
   logic [7:0]           pll_ctrl_reg_ff;
   logic [7:0]           osc_ctrl_ff;
   logic                 aw_got_ff;
   logic                 w_got_ff;
   logic [7:0]           awaddr_ff;
   logic [31:0]          wdata_ff;
   logic                 wstrb0_ff;
   scpm_pkg::scpm_mode_t mode_ff;
   scpm_pkg::scpm_mode_t nxt_mode;
   logic [5:0]           div_cnt_ff;
   logic [2:0]           act_sel_ff;
   logic [1:0]           hs_src_ff;
   logic                 ls_src_ff;
   logic                 hs_tick;
   logic                 ls_tick;
   logic                 sys_tick;
   logic                 halted;

   wire logic [2:0] sys_clk_select  = sys_clk_ctrl_reg_ff[scpm_pkg::SEL_LSB +: 3];
   wire logic       hs_source_select = sys_clk_ctrl_reg_ff[scpm_pkg::HS_SRC_BIT];
   wire logic       ls_source_select = sys_clk_ctrl_reg_ff[scpm_pkg::LS_SRC_BIT];
   wire logic       hs_idle_enable   = sys_clk_ctrl_reg_ff[scpm_pkg::HS_IDLE_BIT];
   wire logic       ls_idle_enable   = sys_clk_ctrl_reg_ff[scpm_pkg::LS_IDLE_BIT];
   wire logic       pll_enable       = pll_ctrl_reg_ff[scpm_pkg::PLL_EN_BIT];
   wire logic       wdt_enable       = osc_ctrl_ff[scpm_pkg::WDT_EN_BIT];
   wire logic       wr_fire          = aw_got_ff && w_got_ff && !S_AXI_BVALID;

   // Merge stored write data into a register byte
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] mask, input logic en);
      merge = en ? ((old & ~mask) | (nw & mask)) : old;
   endfunction

   // Mode code for software readback and the MODE port
   function automatic logic [2:0] mode_code(input scpm_pkg::scpm_mode_t m);
      unique case (m)
         scpm_pkg::MODE_NORMAL:    mode_code = 3'h0;
         scpm_pkg::MODE_SLOW:      mode_code = 3'h1;
         scpm_pkg::MODE_SLEEP:     mode_code = 3'h2;
         scpm_pkg::MODE_IDLE_LS:   mode_code = 3'h3;
         scpm_pkg::MODE_IDLE_BOTH: mode_code = 3'h4;
         scpm_pkg::MODE_IDLE_HS:   mode_code = 3'h5;
      endcase
   endfunction

   // ==========================================================================
   // AXI4-Lite write channel
   // ==========================================================================
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff  <= 32'h0000_0000;
         wstrb0_ff <= 1'b0;
      end
      else if (wr_fire)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_got_ff  <= 1'b1;
            wdata_ff  <= S_AXI_WDATA;
            wstrb0_ff <= S_AXI_WSTRB[0];
         end
      end
   end

   assign S_AXI_AWREADY = !aw_got_ff && !S_AXI_BVALID;
   assign S_AXI_WREADY  = !w_got_ff && !S_AXI_BVALID;

   // Write response, held until accepted
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= scpm_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= (awaddr_ff == scpm_pkg::SYS_CLK_CTRL_OFF ||
                          awaddr_ff == scpm_pkg::PLL_CTRL_OFF ||
                          awaddr_ff == scpm_pkg::OSC_CTRL_OFF ||
                          awaddr_ff == scpm_pkg::STATUS_OFF) ?
                         scpm_pkg::RESP_OKAY : scpm_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
      begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // Register storage; bit 4 of the clock control reads as zero
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sys_clk_ctrl_reg_ff <= scpm_pkg::SYS_CLK_CTRL_RST;
         pll_ctrl_reg_ff     <= scpm_pkg::PLL_CTRL_RST;
         osc_ctrl_ff         <= scpm_pkg::OSC_CTRL_RST;
      end
      else if (wr_fire)
      begin
         sys_clk_ctrl_reg_ff <= merge(sys_clk_ctrl_reg_ff, wdata_ff[7:0], 8'hef,
                                      wstrb0_ff && awaddr_ff == scpm_pkg::SYS_CLK_CTRL_OFF);
         pll_ctrl_reg_ff     <= merge(pll_ctrl_reg_ff, wdata_ff[7:0], 8'h1d,
                                      wstrb0_ff && awaddr_ff == scpm_pkg::PLL_CTRL_OFF);
         osc_ctrl_ff         <= merge(osc_ctrl_ff, wdata_ff[7:0], 8'h0f,
                                      wstrb0_ff && awaddr_ff == scpm_pkg::OSC_CTRL_OFF);
      end
   end

   // ==========================================================================
   // AXI4-Lite read channel
   // ==========================================================================
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h0000_0000;
         S_AXI_RRESP  <= scpm_pkg::RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP  <= scpm_pkg::RESP_OKAY;
         unique case (S_AXI_ARADDR)
            scpm_pkg::SYS_CLK_CTRL_OFF: S_AXI_RDATA <= {24'h0, sys_clk_ctrl_reg_ff};
            scpm_pkg::PLL_CTRL_OFF:     S_AXI_RDATA <= {24'h0, pll_ctrl_reg_ff};
            scpm_pkg::OSC_CTRL_OFF:     S_AXI_RDATA <= {24'h0, osc_ctrl_ff};
            scpm_pkg::STATUS_OFF:       S_AXI_RDATA <= {24'h0, act_sel_ff, 2'h0, mode_code(mode_ff)};
            default:
            begin
               S_AXI_RDATA <= 32'h0000_0000;
               S_AXI_RRESP <= scpm_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ==========================================================================
   // Operating mode
   // ==========================================================================
   // Halt decodes the idle enables as they stand on that edge
   always_comb
   begin
      nxt_mode = mode_ff;
      if (halted)
      begin
         if (WAKE)
            nxt_mode = (act_sel_ff == scpm_pkg::SEL_SUB) ? scpm_pkg::MODE_SLOW
                                                         : scpm_pkg::MODE_NORMAL;
      end
      else if (HALT)
      begin
         unique case ({hs_idle_enable, ls_idle_enable})
            2'b00: nxt_mode = scpm_pkg::MODE_SLEEP;
            2'b01: nxt_mode = scpm_pkg::MODE_IDLE_LS;
            2'b11: nxt_mode = scpm_pkg::MODE_IDLE_BOTH;
            2'b10: nxt_mode = scpm_pkg::MODE_IDLE_HS;
         endcase
      end
      else
      begin
         nxt_mode = (act_sel_ff == scpm_pkg::SEL_SUB) ? scpm_pkg::MODE_SLOW
                                                      : scpm_pkg::MODE_NORMAL;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         mode_ff <= scpm_pkg::MODE_NORMAL;
      else
         mode_ff <= nxt_mode;
   end

   assign halted = mode_ff != scpm_pkg::MODE_NORMAL && mode_ff != scpm_pkg::MODE_SLOW;

   // ==========================================================================
   // Source selection and divider
   // ==========================================================================
   // Source clocks arrive as synchronous enable levels; 2'd2 marks the PLL path
   always_comb
   begin
      unique case (hs_src_ff)
         2'd0:    hs_tick = HS_RC_OSC_CLK;
         2'd1:    hs_tick = HXT_CLK;
         default: hs_tick = PLL_CLK;
      endcase
      ls_tick = ls_src_ff ? LXT_CLK : LS_RC_OSC_CLK;
   end

   // Load only at the wrap point on a quiet cycle: a new source tick cannot land next to an old pulse
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         act_sel_ff <= scpm_pkg::SYS_CLK_CTRL_RST[scpm_pkg::SEL_LSB +: 3];
         hs_src_ff  <= 2'd0;
         ls_src_ff  <= 1'b0;
      end
      else if (div_cnt_ff == 6'h00 && !sys_tick && !SYS_CLK_EN)
      begin
         act_sel_ff <= sys_clk_select;
         hs_src_ff  <= pll_enable ? 2'd2 : {1'b0, hs_source_select};
         ls_src_ff  <= ls_source_select;
      end
   end

   // Counts hs ticks; wraps at 2^code - 1
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         div_cnt_ff <= 6'h00;
      else if (act_sel_ff != scpm_pkg::SEL_SUB && hs_tick)
         div_cnt_ff <= (div_cnt_ff == 6'((7'h01 << act_sel_ff) - 7'h01)) ? 6'h00
                                                                        : div_cnt_ff + 6'h01;
   end

   assign sys_tick = (act_sel_ff == scpm_pkg::SEL_SUB) ? ls_tick
                   : (hs_tick && div_cnt_ff == 6'h00);

   // ==========================================================================
   // Clock gates
   // ==========================================================================
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         SYS_CLK_EN   <= 1'b0;
         GATES        <= '0;
         PLL_FREQ_SEL <= 3'h0;
         MODE         <= 3'h0;
      end
      else
      begin
         SYS_CLK_EN   <= sys_tick && !halted;
         PLL_FREQ_SEL <= pll_ctrl_reg_ff[scpm_pkg::PLL_OS_LSB +: 3];
         MODE         <= mode_code(mode_ff);
         GATES.cpu    <= !halted;
         GATES.hs_osc <= (mode_ff == scpm_pkg::MODE_NORMAL) ||
                         (mode_ff == scpm_pkg::MODE_SLOW &&
                          (hs_source_select ? osc_ctrl_ff[scpm_pkg::HXT_EN_BIT]
                                            : osc_ctrl_ff[scpm_pkg::HS_RC_OSC_EN_BIT])) ||
                         mode_ff == scpm_pkg::MODE_IDLE_BOTH ||
                         mode_ff == scpm_pkg::MODE_IDLE_HS;
         GATES.ls_osc <= !halted || mode_ff == scpm_pkg::MODE_IDLE_LS ||
                         mode_ff == scpm_pkg::MODE_IDLE_BOTH || wdt_enable;
         GATES.sub_periph <= mode_ff != scpm_pkg::MODE_SLEEP;
         GATES.wdt    <= !halted || wdt_enable;
         GATES.pll    <= (mode_ff == scpm_pkg::MODE_SLOW) ? pll_enable
                       : (mode_ff == scpm_pkg::MODE_NORMAL ||
                          mode_ff == scpm_pkg::MODE_IDLE_BOTH) ? pll_enable : 1'b0;
         GATES.usb_active <= mode_ff != scpm_pkg::MODE_SLEEP &&
                             mode_ff != scpm_pkg::MODE_IDLE_LS;
      end
   end

endmodule

`default_nettype wire

// ### verif/scpm_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Mode and clock gate checks
module scpm_top_chk
(
   input wire logic                  REF_CLK,
   input wire logic                  RST_N,
   input wire logic                  HALT,
   input wire logic                  SYS_CLK_EN,
   input wire scpm_pkg::scpm_gates_t GATES,
   input wire logic [2:0]            MODE
);
   logic [1:0] up_ff;
   logic       ok;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // Gates and mode code register together but hold reset zeros at first, so skip those edges
   always_ff @(posedge REF_CLK or negedge RST_N)
      if (!RST_N)
         up_ff <= 2'h0;
      else if (up_ff != 2'h3)
         up_ff <= up_ff + 2'h1;
   assign ok = (up_ff == 2'h3);
   // ====================
   // Gates per mode
   property p_run;
      ok && MODE <= 3'h1 |-> GATES.cpu && GATES.sub_periph;
   endproperty
   a_run: assert property (p_run) else $error("run gates off");
   property p_sleep;
      ok && MODE == 3'h2 |-> !(GATES.cpu || GATES.hs_osc || GATES.sub_periph);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep gates on");
   property p_idle_ls;
      ok && MODE == 3'h3 |-> !GATES.cpu && !GATES.hs_osc && GATES.ls_osc;
   endproperty
   a_idle_ls: assert property (p_idle_ls) else $error("idle ls gates");
   property p_idle_both;
      ok && MODE == 3'h4 |-> !GATES.cpu && GATES.hs_osc && GATES.ls_osc;
   endproperty
   a_idle_both: assert property (p_idle_both) else $error("idle both gates");
   property p_idle_hs;
      ok && MODE == 3'h5 |-> !GATES.cpu && GATES.hs_osc;
   endproperty
   a_idle_hs: assert property (p_idle_hs) else $error("idle hs gates");
   property p_usb;
      ok && (MODE == 3'h2 || MODE == 3'h3) |-> !GATES.usb_active;
   endproperty
   a_usb: assert property (p_usb) else $error("usb active");
   // ====================
   // Halt entry and system clock
   property p_halt;
      HALT && MODE <= 3'h1 |=> ##1 (MODE >= 3'h2 && MODE <= 3'h5 && !GATES.cpu);
   endproperty
   a_halt: assert property (p_halt) else $error("halt not decoded");
   property p_halt_clk;
      ok && MODE >= 3'h2 && $past(MODE) >= 3'h2 && $past(MODE, 2) >= 3'h2 |-> !SYS_CLK_EN;
   endproperty
   a_halt_clk: assert property (p_halt_clk) else $error("clock while halted");
   property p_no_runt;
      SYS_CLK_EN |=> !SYS_CLK_EN;
   endproperty
   a_no_runt: assert property (p_no_runt) else $error("short clock period");
   c_sleep: cover property (MODE == 3'h2);
   c_both: cover property (MODE == 3'h4);
   c_hs: cover property (MODE == 3'h5);
endmodule
bind scpm_top scpm_top_chk chk_u
(
   .REF_CLK(REF_CLK), .RST_N(RST_N), .HALT(HALT), .SYS_CLK_EN(SYS_CLK_EN),
   .GATES(GATES), .MODE(MODE)
);
`default_nettype wire

// ### verif/test_system_clock_and_power_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_system_clock_and_power_mode_control;
   logic        clk, rst_n, hs_crystal_osc, hs_rc_osc, pll, ls_crystal_osc, ls_rc_osc, halt, wake, sce;
   logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
   logic [7:0]  aw_a, ar_a;
   logic [31:0] w_d, r_d;
   logic [3:0]  w_s;
   logic [1:0]  b_rsp, r_rsp;
   logic [2:0]  pfs, mode;
   int          n_mismatch, tests_run, tick;
   scpm_pkg::scpm_gates_t gates;
   scpm_top dut_u
   (
      .REF_CLK(clk), .RST_N(rst_n), .HXT_CLK(hs_crystal_osc), .HS_RC_OSC_CLK(hs_rc_osc), .PLL_CLK(pll),
      .LXT_CLK(ls_crystal_osc), .LS_RC_OSC_CLK(ls_rc_osc), .HALT(halt), .WAKE(wake), .SYS_CLK_EN(sce),
      .GATES(gates), .PLL_FREQ_SEL(pfs), .MODE(mode),
      .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_r),
      .S_AXI_WDATA(w_d), .S_AXI_WSTRB(w_s), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r),
      .S_AXI_BRESP(b_rsp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
      .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_r),
      .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_rsp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r)
   );
   // ====================
   // Clock and source ticks; distinct periods make each source recognisable
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      tick <= tick + 1;
      hs_crystal_osc  <= (tick % 3 == 0);
      hs_rc_osc <= (tick % 4 == 0);
      pll  <= (tick % 5 == 0);
      ls_crystal_osc  <= (tick % 7 == 0);
      ls_rc_osc <= (tick % 9 == 0);
   end
   // ====================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge clk);
      aw_a <= a;
      w_d  <= d;
      w_s  <= 4'hf;
      aw_v <= 1'b1;
      w_v  <= 1'b1;
      b_r  <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (aw_r)
            aw_v <= 1'b0;
         if (w_r)
            w_v <= 1'b0;
      end
      while (!b_v && n < 300);
      b_r <= 1'b0;
      chk(b_rsp, er);
      chk(b_v, 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n = 0;
      @(posedge clk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r  <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (ar_r)
            ar_v <= 1'b0;
      end
      while (!r_v && n < 300);
      r_r <= 1'b0;
      chk(r_d, e);
      chk(r_rsp, er);
      chk(r_v, 1'b1);
   endtask
   // Interval between the 3rd and 4th pulses, clear of any switch-over
   task automatic per(input int e);
      int n;
      repeat (4)
      begin
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
         end
         while (sce !== 1'b1 && n < 2000);
      end
      chk(n, e);
   endtask
   // ====================
   // Scenarios
   task automatic t_regs();
      rd(8'h00, 32'h40, 2'h0);
      rd(8'h08, 32'h02, 2'h0);
      rd(8'h0c, 32'h40, 2'h0);
      rd(8'h10, 32'h00, 2'h2);
      wr(8'h10, 32'hff, 2'h2);
      wr(8'h00, 32'h5f, 2'h0);
      rd(8'h00, 32'h4f, 2'h0);
   endtask
   task automatic t_div();
      for (int c = 0; c < 7; c++)
      begin
         wr(8'h00, c << 5, 2'h0);
         per(4 << c);
      end
   endtask
   task automatic t_src();
      wr(8'h08, 32'h0f, 2'h0);
      wr(8'h00, 32'h08, 2'h0);
      per(3);
      wr(8'h04, 32'h15, 2'h0);
      per(5);
      chk(pfs, 3'h5);
      wr(8'h04, 32'h00, 2'h0);
      wr(8'h00, 32'he0, 2'h0);
      per(9);
      chk(mode, 3'h1);
      wr(8'h00, 32'he4, 2'h0);
      per(7);
   endtask
   task automatic t_slow();
      logic [7:0] v [4] = '{8'h04, 8'h06, 8'h00, 8'h00};
      for (int k = 0; k < 4; k++)
      begin
         wr(k < 2 ? 8'h08 : 8'h04, {24'h0, v[k] | 8'(k == 2)}, 2'h0);
         repeat (4) @(posedge clk);
         if (k < 2)
            chk(gates.hs_osc, k == 1);
         else
            chk(gates.pll, k == 2);
      end
      chk(gates.sub_periph, 1'b1);
   endtask
   task automatic t_halt();
      logic [2:0] m [4] = '{3'h2, 3'h3, 3'h5, 3'h4};
      logic [1:0] idle;
      for (int k = 0; k < 8; k++)
      begin
         idle = 2'(k);
         wr(8'h08, {28'h0, k[2], 3'h2}, 2'h0);
         wr(8'h00, {30'h0, idle}, 2'h0);
         repeat (20) @(posedge clk);
         halt <= 1'b1;
         @(posedge clk);
         halt <= 1'b0;
         repeat (3) @(posedge clk);
         chk(mode, m[idle]);
         chk(gates.cpu, 1'b0);
         chk(gates.hs_osc, idle[1]);
         chk(gates.ls_osc, idle[0] | k[2]);
         chk(gates.wdt, k[2]);
         wake <= 1'b1;
         @(posedge clk);
         wake <= 1'b0;
         repeat (3) @(posedge clk);
         chk(gates.cpu, 1'b1);
      end
   endtask
   // Second reset in mid-run must restore the select field
   task automatic t_rst();
      wr(8'h00, 32'he4, 2'h0);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h40, 2'h0);
   endtask
   task give_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ====================
   // Main sequence
   initial
   begin
      {rst_n, halt, wake, aw_v, w_v, b_r, ar_v, r_r} = 8'h00;
      {aw_a, ar_a, w_d, w_s} = 52'h0;
      {hs_crystal_osc, hs_rc_osc, pll, ls_crystal_osc, ls_rc_osc} = 5'h00;
      tick = 0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_div();
      t_src();
      t_slow();
      t_halt();
      t_rst();
      give_verdict();
   end
   // Whole run needs well under this span; a hang is cut short here
   initial
   begin
      #200000;
      n_mismatch++;
      give_verdict();
   end
endmodule
`default_nettype wire
